// File: src/imw_consts.vh
`ifndef IMW_CONSTS_VH
`define IMW_CONSTS_VH

// Register index within the paged map
`define IMW_ADDR_MASK3 5'h1D
// Register width and reset value
`define IMW_DATA_W 8
`define IMW_MASK3_RESET 5'h00
// Bit positions of the mask word
`define IMW_BIT_SIG 0
`define IMW_BIT_RCR 1
`define IMW_BIT_FIVE 2
`define IMW_BIT_ONE 3
`define IMW_BIT_JIT 4
`define IMW_MASK_W 5
// Near-slip margin of the jitter FIFO, in bytes
`define IMW_JIT_MARGIN 4

`endif

// File: src/imw_mask_three.v
`timescale 1ns/1ps
`include "imw_consts.vh"

// History register and change detector for one group of levels
module imw_edge_det #(
	parameter W = 1,
	parameter ANY_CHANGE = 0
) (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Watched levels
	input wire [W-1:0] level,
	// Detected event
	output wire seen
);

	reg [W-1:0] prev_q;
	wire [W-1:0] prev_d;
	wire [W-1:0] rise;
	wire [W-1:0] flip;

	assign prev_d = level;
	assign rise = level & ~prev_q;
	assign flip = level ^ prev_q;
	// Any change or rising edge only
	assign seen = (ANY_CHANGE != 0) ? |flip : |rise;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= {W{1'h0}};
		end else begin
			prev_q <= prev_d;
		end
	end

endmodule // imw_edge_det

module imw_mask_three #(
	parameter FIFO_DEPTH = 32,
	parameter FILL_W = 6,
	parameter SIG_W = 120
) (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Register port
	input wire [4:0] reg_addr,
	input wire page_sel,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_q,
	// Event sources
	input wire [FILL_W-1:0] jitter_fifo_fill,
	input wire one_second_tick_flag,
	input wire five_second_tick_flag,
	input wire remote_alarm_crc_flag,
	input wire [SIG_W-1:0] abcd_bits,
	// Interrupt request
	output reg irq_q
);

	// Near-slip thresholds cut to the fill width
	localparam integer LOW_INT = `IMW_JIT_MARGIN;
	localparam integer HIGH_INT = FIFO_DEPTH - `IMW_JIT_MARGIN;
	localparam [FILL_W-1:0] LOW_LIM = LOW_INT[FILL_W-1:0];
	localparam [FILL_W-1:0] HIGH_LIM = HIGH_INT[FILL_W-1:0];
	// Unused upper bits of the read word
	localparam PAD_W = `IMW_DATA_W - `IMW_MASK_W;

	// Register state and next values
	reg [`IMW_MASK_W-1:0] mask_q;
	reg [`IMW_MASK_W-1:0] mask_d;
	reg [`IMW_DATA_W-1:0] reg_rdata_d;
	reg irq_d;
	// Low for the first cycle after reset
	reg prim_q;

	// Address decode
	wire hit;
	wire wr_hit;
	wire rd_hit;

	// Mask fields
	wire jitter_fifo_near_slip_mask;
	wire one_second_tick_mask;
	wire five_second_tick_mask;
	wire remote_alarm_crc_mask;
	wire signalling_change_mask;

	// Raw events
	wire near_low;
	wire near_high;
	wire near_slip;
	wire one_second_tick_irq;
	wire five_rise;
	wire remote_alarm_crc_irq;
	wire sig_change;

	// Events after masking
	wire gate_jit;
	wire gate_one;
	wire gate_five;
	wire gate_rcr;
	wire gate_sig;

	assign hit = page_sel && (reg_addr == `IMW_ADDR_MASK3);
	assign wr_hit = reg_wr && hit;
	assign rd_hit = reg_rd && hit;

	assign jitter_fifo_near_slip_mask = mask_q[`IMW_BIT_JIT];
	assign one_second_tick_mask = mask_q[`IMW_BIT_ONE];
	assign five_second_tick_mask = mask_q[`IMW_BIT_FIVE];
	assign remote_alarm_crc_mask = mask_q[`IMW_BIT_RCR];
	assign signalling_change_mask = mask_q[`IMW_BIT_SIG];

	assign near_low = (jitter_fifo_fill <= LOW_LIM);
	assign near_high = (jitter_fifo_fill >= HIGH_LIM);
	assign near_slip = near_low || near_high;

	imw_edge_det #(
		.W(1),
		.ANY_CHANGE(0)
	) u_one_edge (
		.core_clk(core_clk),
		.rstn(rstn),
		.level(one_second_tick_flag),
		.seen(one_second_tick_irq)
	);

	imw_edge_det #(
		.W(1),
		.ANY_CHANGE(0)
	) u_five_edge (
		.core_clk(core_clk),
		.rstn(rstn),
		.level(five_second_tick_flag),
		.seen(five_rise)
	);

	imw_edge_det #(
		.W(1),
		.ANY_CHANGE(0)
	) u_rcr_edge (
		.core_clk(core_clk),
		.rstn(rstn),
		.level(remote_alarm_crc_flag),
		.seen(remote_alarm_crc_irq)
	);

	imw_edge_det #(
		.W(SIG_W),
		.ANY_CHANGE(1)
	) u_sig_change (
		.core_clk(core_clk),
		.rstn(rstn),
		.level(abcd_bits),
		.seen(sig_change)
	);

	assign gate_jit = near_slip && jitter_fifo_near_slip_mask;
	assign gate_one = one_second_tick_irq && one_second_tick_mask;
	assign gate_five = five_rise && five_second_tick_mask;
	assign gate_rcr = remote_alarm_crc_irq && remote_alarm_crc_mask;
	assign gate_sig = sig_change && signalling_change_mask;

	// Write keeps the mask bits only
	always @* begin
		mask_d = mask_q;
		if (wr_hit) begin
			mask_d = reg_wdata[`IMW_MASK_W-1:0];
		end
	end

	always @* begin
		reg_rdata_d = {`IMW_DATA_W{1'h0}};
		if (rd_hit) begin
			reg_rdata_d = {{PAD_W{1'h0}}, mask_q};
		end
	end

	always @* begin
		irq_d = 1'h0;
		// First cycle only loads history
		if (prim_q) begin
			irq_d = gate_jit || gate_one || gate_five ||
				gate_rcr || gate_sig;
		end
	end

	// State registers
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mask_q <= `IMW_MASK3_RESET;
			reg_rdata_q <= {`IMW_DATA_W{1'h0}};
			irq_q <= 1'h0;
			prim_q <= 1'h0;
		end else begin
			mask_q <= mask_d;
			reg_rdata_q <= reg_rdata_d;
			irq_q <= irq_d;
			prim_q <= 1'h1;
		end
	end

endmodule // imw_mask_three

// File: test/imw_host.sv
`timescale 1ns/1ps
module imw_host(input wire core_clk,output reg [4:0] reg_addr,
output reg page_sel,reg_wr,reg_rd,output reg [7:0] reg_wdata,
input wire [7:0] reg_rdata_q);
task acc(input [4:0] x,input [7:0] y,input k,output [7:0] v);
begin @(negedge core_clk);
{reg_addr,page_sel,reg_wr,reg_rd,reg_wdata}={x,1'h1,~k,k,y};
@(negedge core_clk); {reg_wr,reg_rd}=2'h0; v=reg_rdata_q; end endtask
initial {reg_addr,page_sel,reg_wr,reg_rd,reg_wdata}=0;
endmodule // imw_host

// File: test/imw_mask_three_monitor.sv
`timescale 1ns/1ps
module imw_mon #(parameter FIFO_DEPTH=32,FILL_W=6,SIG_W=120)(input wire
core_clk,rstn,reg_wr,reg_rd,page_sel,one_second_tick_flag,irq_q,
five_second_tick_flag,remote_alarm_crc_flag,input wire [4:0] reg_addr,
input wire [7:0] reg_wdata,reg_rdata_q,input wire [FILL_W-1:0]
jitter_fifo_fill,input wire [SIG_W-1:0] abcd_bits);
reg [4:0] m_q;
wire hit=page_sel&&reg_addr==5'h1D;
always @(posedge core_clk or negedge rstn) if(!rstn) m_q<=5'h00;
else if(reg_wr&&hit) m_q<=reg_wdata[4:0];
default clocking @(posedge core_clk); endclocking
default disable iff(!rstn);
AST_JIT: assert property(m_q[4]&&(jitter_fifo_fill<=4||
jitter_fifo_fill>=FIFO_DEPTH-4)|=>irq_q)else $error("jit");
AST_ONE: assert property(m_q[3]&&$rose(one_second_tick_flag)
|=>irq_q)else $error("one");
AST_FIVE: assert property(m_q[2]&&$rose(five_second_tick_flag)
|=>irq_q)else $error("five");
AST_RCR: assert property(m_q[1]&&$rose(remote_alarm_crc_flag)
|=>irq_q)else $error("rcr");
AST_SIG: assert property(m_q[0]&&abcd_bits!=$past(abcd_bits)
|=>irq_q)else $error("sig");
AST_OFF: assert property(m_q==5'h00|=>!irq_q)else $error("off");
AST_RD: assert property(reg_rd&&hit&&!reg_wr|=>
reg_rdata_q=={3'h0,m_q})else $error("rd");
AST_IDLE: assert property(!(reg_rd&&hit)|=>reg_rdata_q==8'h00)
else $error("idle");
endmodule // imw_mon

// File: test/tb_imw_mask_three.sv
`timescale 1ns/1ps
module tb_imw_mask_three;
reg core_clk=0,rstn=0,one_second_tick_flag=0,five_second_tick_flag=0;
reg remote_alarm_crc_flag=0,z;
reg [5:0] jitter_fifo_fill=6'h10;
reg [119:0] abcd_bits=0;
reg [7:0] v;
wire [4:0] reg_addr;
wire page_sel,reg_wr,reg_rd,irq_q;
wire [7:0] reg_wdata,reg_rdata_q;
int n_errors=0,cmp_count=0,t=0,p,i;
imw_host h(.core_clk(core_clk),.reg_addr(reg_addr),.page_sel(page_sel),
.reg_wr(reg_wr),.reg_rd(reg_rd),.reg_wdata(reg_wdata),
.reg_rdata_q(reg_rdata_q));
imw_mask_three dut(.core_clk(core_clk),.rstn(rstn),.reg_addr(reg_addr),
.page_sel(page_sel),.reg_wr(reg_wr),.reg_rd(reg_rd),.reg_wdata(reg_wdata),
.reg_rdata_q(reg_rdata_q),.jitter_fifo_fill(jitter_fifo_fill),
.one_second_tick_flag(one_second_tick_flag),
.five_second_tick_flag(five_second_tick_flag),
.remote_alarm_crc_flag(remote_alarm_crc_flag),.abcd_bits(abcd_bits),
.irq_q(irq_q));
always #50 core_clk=~core_clk;
always @(posedge core_clk) if(++t>900) begin n_errors++; conclude; end
task ck(input string n,input [7:0] e,s);
begin cmp_count++; if(s!==e) begin n_errors++;
$display("[ERR] %s exp %h got %h",n,e,s); end end endtask
task conclude;
begin $display("cmp %0d err %0d",cmp_count,n_errors);
if(n_errors==0&&cmp_count>0) $display("Regression OK");
else $display("Regression broken");
$finish; end endtask
initial begin
repeat(10) @(negedge core_clk); rstn=1;
h.acc(5'h1D,8'hFF,0,v); h.acc(5'h1D,0,1,v); ck("mask",8'h1F,v);
h.acc(5'h1E,0,1,v); ck("other",0,v);
$display("regs done");
for(p=0;p<2;p++) for(i=0;i<5;i++) begin
h.acc(5'h1D,p?8'h01<<i:8'hE0,0,v);
jitter_fifo_fill=i==4?6'h02:6'h10; abcd_bits[9]^=i==0;
{one_second_tick_flag,five_second_tick_flag,remote_alarm_crc_flag}=3'((1<<i)>>1);
z=0; repeat(2) begin @(negedge core_clk); z|=irq_q; end
ck("irq",8'(p),{7'h0,z});
jitter_fifo_fill=6'h10; {one_second_tick_flag,five_second_tick_flag}=0;
remote_alarm_crc_flag=0; z=0;
repeat(3) begin @(negedge core_clk); z|=irq_q; end
ck("fall",0,{7'h0,z});
end
$display("events done");
conclude;
end
endmodule // tb_imw_mask_three
bind imw_mask_three imw_mon #(.FIFO_DEPTH(FIFO_DEPTH),.FILL_W(FILL_W),
.SIG_W(SIG_W)) mon(.core_clk(core_clk),.rstn(rstn),.reg_wr(reg_wr),
.reg_rd(reg_rd),.page_sel(page_sel),
.one_second_tick_flag(one_second_tick_flag),.irq_q(irq_q),
.five_second_tick_flag(five_second_tick_flag),
.remote_alarm_crc_flag(remote_alarm_crc_flag),.reg_addr(reg_addr),
.reg_wdata(reg_wdata),.reg_rdata_q(reg_rdata_q),
.jitter_fifo_fill(jitter_fifo_fill),.abcd_bits(abcd_bits));
